// [design/pwmc_pkg.sv]
/*
 * Shared constants and types for the PWM counter control block: register
 * offsets, field positions, reset values, divider encodings and the packed
 * carriers used between the register port and the core.
 * Assumes an 8-bit register port with 8-bit offsets.
 */
package pwmc_pkg;

    localparam int unsigned PWMC_ADDR_W  = 8;
    localparam int unsigned PWMC_DATA_W  = 8;
    localparam int unsigned PWMC_CNT_W   = 8;
    localparam int unsigned PWMC_PRESC_W = 6;

    // Register offsets.
    localparam logic [7:0] PWMC_OFF_CONTROL = 8'hEF;
    localparam logic [7:0] PWMC_OFF_DUTY    = 8'hF1;
    localparam logic [7:0] PWMC_OFF_STATUS  = 8'hF3;
    localparam logic [7:0] PWMC_OFF_MASK    = 8'hF4;
    localparam logic [7:0] PWMC_OFF_COUNT   = 8'hF6;
    localparam logic [7:0] PWMC_OFF_PERIOD  = 8'hF7;

    // Control field positions.
    localparam int unsigned PWMC_CTL_SEL_HI = 7;
    localparam int unsigned PWMC_CTL_SEL_LO = 6;
    localparam int unsigned PWMC_CTL_POL    = 5;
    localparam int unsigned PWMC_CTL_CLR    = 4;
    localparam int unsigned PWMC_CTL_EN     = 3;
    localparam int unsigned PWMC_CTL_AMT    = 2;
    localparam int unsigned PWMC_CTL_OVFIE  = 1;
    localparam int unsigned PWMC_CTL_PEND   = 0;

    // Status field positions.
    localparam int unsigned PWMC_ST_OVF   = 0;
    localparam int unsigned PWMC_ST_MATCH = 1;
    localparam int unsigned PWMC_ST_TRIP  = 2;

    // Reset values.
    localparam logic [7:0] PWMC_CONTROL_RST = 8'h00;
    localparam logic [7:0] PWMC_DUTY_RST    = 8'h00;
    localparam logic [7:0] PWMC_STATUS_RST  = 8'h00;
    localparam logic [7:0] PWMC_MASK_RST    = 8'h01;
    localparam logic [7:0] PWMC_PERIOD_RST  = 8'hFF;
    localparam logic [7:0] PWMC_READ_ZERO   = 8'h00;

    // Input clock select codes and the matching prescaler masks.
    localparam logic [1:0] PWMC_SEL_DIV64 = 2'h0;
    localparam logic [1:0] PWMC_SEL_DIV8  = 2'h1;
    localparam logic [1:0] PWMC_SEL_DIV2  = 2'h2;
    localparam logic [1:0] PWMC_SEL_DIV1  = 2'h3;

    localparam logic [PWMC_PRESC_W-1:0] PWMC_MASK_DIV64 = 6'h3F;
    localparam logic [PWMC_PRESC_W-1:0] PWMC_MASK_DIV8  = 6'h07;
    localparam logic [PWMC_PRESC_W-1:0] PWMC_MASK_DIV2  = 6'h01;
    localparam logic [PWMC_PRESC_W-1:0] PWMC_MASK_DIV1  = 6'h00;

    typedef struct packed {
        logic [PWMC_ADDR_W-1:0] addr;
        logic [PWMC_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } pwmc_bus_req_type;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic       pol;
        logic       clr;
        logic       en;
        logic       amt;
        logic       ovf_ie;
        logic       pend;
    } pwmc_ctrl_type;

    function automatic logic [PWMC_PRESC_W-1:0] pwmc_div_mask(input logic [1:0] sel);
        logic [PWMC_PRESC_W-1:0] m;
        m = PWMC_MASK_DIV64;
        case (sel)
            PWMC_SEL_DIV64: m = PWMC_MASK_DIV64;
            PWMC_SEL_DIV8:  m = PWMC_MASK_DIV8;
            PWMC_SEL_DIV2:  m = PWMC_MASK_DIV2;
            PWMC_SEL_DIV1:  m = PWMC_MASK_DIV1;
            default:        m = PWMC_MASK_DIV64;
        endcase
        return m;
    endfunction

endpackage

// [design/pwmc_prescaler.sv]
/*
 * Prescaler that turns the oscillator clock into counter advance ticks at
 * one of four division ratios.
 * Assumes run comes from registered control state and clear from the bus write strobe, both in ref_clk.
 */
`timescale 1ns/1ns
module pwmc_prescaler
    import pwmc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       run,
    input  wire logic       clear,
    input  wire logic [1:0] clk_sel,
    output logic            tick
);

    typedef struct packed {
        logic [PWMC_PRESC_W-1:0] cnt;
    } pwmc_presc_state_type;

    pwmc_presc_state_type     state_ff;
    pwmc_presc_state_type     nxt_state;
    logic [PWMC_PRESC_W-1:0]  div_mask;

    assign div_mask = pwmc_div_mask(clk_sel);
    // A tick lands when the low bits covered by the mask are all ones.
    assign tick     = run && ((state_ff.cnt & div_mask) == div_mask);

    always_comb begin
        nxt_state = state_ff;
        if (clear || !run) begin
            nxt_state.cnt = '0;
        end else begin
            nxt_state.cnt = state_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

endmodule

// [design/pwmc_top.sv]
/*
 * PWM counter control block: control register, prescaled 8-bit counter,
 * duty comparison with polarity and anti-mis-trigger blanking, and the
 * overflow, match and trip interrupt flags.
 * Assumes a single-cycle strobe register port in the ref_clk domain and a
 * comparator input already synchronous to ref_clk.
 */
// Functional notes
// - Control register at EFH, resets to zero.
// - Bits 7:6 pick divide 64, 8, 2, 1.
// - Bit 5 set inverts the PWM output.
// - Writing one to bit 4 clears counter.
// - Bit 3 runs the counter, zero stops it.
// - Bit 2 enables anti-mis-trigger blanking.
// - Bit 1 gates the overflow interrupt request.
// - Bit 0 shows pending; write zero clears.
`timescale 1ns/1ns
module pwmc_top
    import pwmc_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    input  wire pwmc_bus_req_type       bus_req,
    output logic [PWMC_DATA_W-1:0]      rd_data,
    input  wire logic                   comparator_zero,
    output logic                        pwm_out,
    output logic                        irq
);

    typedef struct packed {
        pwmc_ctrl_type          ctrl;
        logic [PWMC_CNT_W-1:0]  duty;
        logic [PWMC_CNT_W-1:0]  period;
        logic [PWMC_CNT_W-1:0]  cnt;
        logic [7:0]             status;
        logic [7:0]             mask;
        logic [PWMC_DATA_W-1:0] rd_data;
        logic                   cmp_q;
        logic                   pwm_out;
        logic                   irq;
    } pwmc_state_type;

    pwmc_state_type          state_ff;
    pwmc_state_type          nxt_state;
    pwmc_ctrl_type           wr_ctrl_val;
    logic                    tick;
    logic                    wr_control;
    logic                    wr_duty;
    logic                    wr_status;
    logic                    wr_mask;
    logic                    wr_period;
    logic                    cnt_clear;
    logic                    ovf_event;
    logic                    match_event;
    logic                    trip_event;
    logic                    blank;
    logic                    active;
    logic [7:0]              events;
    logic [7:0]              clears;
    logic [7:0]              eff_mask;

    assign wr_ctrl_val = pwmc_ctrl_type'(bus_req.wdata);
    assign wr_control  = bus_req.wr && (bus_req.addr == PWMC_OFF_CONTROL);
    assign wr_duty     = bus_req.wr && (bus_req.addr == PWMC_OFF_DUTY);
    assign wr_status   = bus_req.wr && (bus_req.addr == PWMC_OFF_STATUS);
    assign wr_mask     = bus_req.wr && (bus_req.addr == PWMC_OFF_MASK);
    assign wr_period   = bus_req.wr && (bus_req.addr == PWMC_OFF_PERIOD);
    assign cnt_clear   = wr_control && wr_ctrl_val.clr;

    // The prescaler is held at zero while stopped so that a restart always
    // begins a full input clock period, at the cost of no phase memory.
    pwmc_prescaler u_prescaler (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .run     (state_ff.ctrl.en),
        .clear   (cnt_clear),
        .clk_sel (state_ff.ctrl.clk_sel),
        .tick    (tick)
    );

    always_comb begin
        nxt_state   = state_ff;
        ovf_event   = 1'b0;
        match_event = 1'b0;
        events      = '0;
        clears      = '0;
        eff_mask    = state_ff.mask;

        // Counter: a software clear takes priority over a tick in the same
        // cycle, and no overflow is counted for that tick.
        if (cnt_clear) begin
            nxt_state.cnt = '0;
        end else if (tick) begin
            match_event = (state_ff.cnt == state_ff.duty);
            if (state_ff.cnt == state_ff.period) begin
                nxt_state.cnt = '0;
                ovf_event     = 1'b1;
            end else begin
                nxt_state.cnt = state_ff.cnt + 1'b1;
            end
        end

        // Trip: the comparator rose while blanking is enabled.
        trip_event      = state_ff.ctrl.amt && comparator_zero && !state_ff.cmp_q;
        nxt_state.cmp_q = comparator_zero;

        if (wr_control) begin
            nxt_state.ctrl.clk_sel = wr_ctrl_val.clk_sel;
            nxt_state.ctrl.pol     = wr_ctrl_val.pol;
            nxt_state.ctrl.en      = wr_ctrl_val.en;
            nxt_state.ctrl.amt     = wr_ctrl_val.amt;
            nxt_state.ctrl.ovf_ie  = wr_ctrl_val.ovf_ie;
            // Writing zero clears pending, writing one leaves it alone.
            clears[PWMC_ST_OVF]    = !wr_ctrl_val.pend;
        end
        // The clear action is write-only; the stored bit always reads zero.
        nxt_state.ctrl.clr = 1'b0;

        if (wr_status) begin
            clears = clears | bus_req.wdata;
        end
        events[PWMC_ST_OVF]   = ovf_event;
        events[PWMC_ST_MATCH] = match_event;
        events[PWMC_ST_TRIP]  = trip_event;
        // An event in the cycle of its clear wins over the clear.
        nxt_state.status    = (state_ff.status & ~clears) | events;
        nxt_state.ctrl.pend = nxt_state.status[PWMC_ST_OVF];

        if (wr_mask) begin
            nxt_state.mask = bus_req.wdata;
        end
        if (wr_duty) begin
            nxt_state.duty = bus_req.wdata;
        end
        if (wr_period) begin
            nxt_state.period = bus_req.wdata;
        end

        // Read data stand for exactly one cycle; unmapped offsets read zero.
        nxt_state.rd_data = PWMC_READ_ZERO;
        if (bus_req.rd) begin
            case (bus_req.addr)
                PWMC_OFF_CONTROL: nxt_state.rd_data = state_ff.ctrl;
                PWMC_OFF_DUTY:    nxt_state.rd_data = state_ff.duty;
                PWMC_OFF_STATUS:  nxt_state.rd_data = state_ff.status;
                PWMC_OFF_MASK:    nxt_state.rd_data = state_ff.mask;
                PWMC_OFF_COUNT:   nxt_state.rd_data = state_ff.cnt;
                PWMC_OFF_PERIOD:  nxt_state.rd_data = state_ff.period;
                default:          nxt_state.rd_data = PWMC_READ_ZERO;
            endcase
        end

        // Output: the active phase is cnt below duty; blanking and a stopped
        // counter both force the inactive level, which tracks polarity.
        active            = state_ff.ctrl.en && (state_ff.cnt < state_ff.duty);
        blank             = state_ff.ctrl.amt && comparator_zero;
        nxt_state.pwm_out = (active && !blank) ^ state_ff.ctrl.pol;

        // The overflow source also needs its own enable bit in control.
        eff_mask[PWMC_ST_OVF] = state_ff.mask[PWMC_ST_OVF] && state_ff.ctrl.ovf_ie;
        nxt_state.irq         = |(state_ff.status & eff_mask);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff.ctrl    <= pwmc_ctrl_type'(PWMC_CONTROL_RST);
            state_ff.duty    <= PWMC_DUTY_RST;
            state_ff.period  <= PWMC_PERIOD_RST;
            state_ff.cnt     <= '0;
            state_ff.status  <= PWMC_STATUS_RST;
            state_ff.mask    <= PWMC_MASK_RST;
            state_ff.rd_data <= PWMC_READ_ZERO;
            state_ff.cmp_q   <= 1'b0;
            state_ff.pwm_out <= 1'b0;
            state_ff.irq     <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rd_data = state_ff.rd_data;
    assign pwm_out = state_ff.pwm_out;
    assign irq     = state_ff.irq;

endmodule

// [dv/pwmc_checker.sv]
/* Port assertions for the PWM counter control block.
   Assumes the status mask register stays at its reset value. */
`timescale 1ns/1ns
module pwmc_checker
    import pwmc_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    input  wire pwmc_bus_req_type       bus_req,
    input  wire logic [PWMC_DATA_W-1:0] rd_data,
    input  wire logic                   comparator_zero,
    input  wire logic                   pwm_out,
    input  wire logic                   irq
);
    // Shadow of the writable control bits; the clear bit never reads back.
    logic [7:0] ctl_ff;
    logic       ctl_wr;
    logic       blank;
    logic       mapped;
    assign ctl_wr = bus_req.wr && bus_req.addr == PWMC_OFF_CONTROL;
    assign blank  = ctl_ff[PWMC_CTL_AMT] && comparator_zero;
    assign mapped = bus_req.addr inside {8'hEF, 8'hF1, 8'hF3, 8'hF4, 8'hF6, 8'hF7};
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_ff <= 8'h00;
        end else if (ctl_wr) begin
            ctl_ff <= bus_req.wdata & 8'hEE;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    rd_idle_a: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
        else $error("read data outside a read cycle");
    unmapped_rd_a: assert property (bus_req.rd && !mapped |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    ctl_read_a: assert property (bus_req.rd && bus_req.addr == PWMC_OFF_CONTROL
        |=> rd_data[7:1] == $past(ctl_ff[7:1]))
        else $error("control readback wrong");
    stop_level_a: assert property (!$past(ctl_ff[PWMC_CTL_EN])
        |-> pwm_out == $past(ctl_ff[PWMC_CTL_POL]))
        else $error("stopped output not at idle level");
    blank_out_a: assert property ($past(blank) |-> pwm_out == $past(ctl_ff[PWMC_CTL_POL]))
        else $error("output not blanked");
    irq_gate_a: assert property ($rose(irq) |-> $past(ctl_ff[PWMC_CTL_OVFIE]))
        else $error("interrupt while disabled");
    irq_clear_a: assert property (ctl_wr && !bus_req.wdata[PWMC_CTL_PEND]
        && !bus_req.wdata[PWMC_CTL_EN] && !ctl_ff[PWMC_CTL_EN] |-> ##2 !irq)
        else $error("pending not cleared");
    irq_stay_a: assert property (irq && !bus_req.wr && !$past(bus_req.wr) |=> irq)
        else $error("pending dropped by itself");
    cover property (ctl_wr && bus_req.wdata[PWMC_CTL_CLR]);
    cover property ($rose(irq));
    cover property (blank && ctl_ff[PWMC_CTL_EN]);
endmodule

// [dv/tb.sv]
/* Register-level bench for the PWM counter control block.
   Assumes a one-cycle strobe port with read data in the next cycle. */
`timescale 1ns/1ns
bind pwmc_top pwmc_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .bus_req(bus_req), .rd_data(rd_data), .comparator_zero(comparator_zero),
    .pwm_out(pwm_out), .irq(irq));
module tb;
    import pwmc_pkg::*;
    logic                   ref_clk;
    logic                   reset_n;
    logic                   comparator_zero;
    logic                   pwm_out;
    logic                   irq;
    logic [PWMC_DATA_W-1:0] rd_data;
    pwmc_bus_req_type       bus_req;
    int                     err_total;
    int                     n_tests;
    int                     n;
    int                     dv [4] = '{64, 8, 2, 1};
    pwmc_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req),
        .rd_data(rd_data), .comparator_zero(comparator_zero), .pwm_out(pwm_out), .irq(irq));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req <= '0;
        #1;
        check($sformatf("reg %h", a), rd_data, exp);
    endtask
    // Counts high samples over two whole periods of four, so phase does not matter.
    task automatic highs(input logic [7:0] exp);
        n = 0;
        repeat (8) begin
            @(posedge ref_clk);
            #1;
            if (pwm_out === 1'b1) n++;
        end
        check("pwm_out highs", 8'(n), exp);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        results();
    end
    initial begin
        bus_req = '0;
        comparator_zero = 1'b0;
        reset_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(8'hEF, 8'h00);
        wr(8'hEE, 8'hFF);
        rd(8'hEE, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(8'hEF, 8'h10);
            rd(8'hF6, 8'h00);
            // The linkage register lies outside this block; the bench counts it as set first.
            wr(8'hEF, {2'(i), 6'h08});
            repeat (130) @(posedge ref_clk);
            rd(8'hF6, 8'(131 / dv[i]));
            wr(8'hEF, {2'(i), 6'h00});
            repeat (20) @(posedge ref_clk);
            rd(8'hF6, 8'(134 / dv[i]));
        end
        wr(8'hF7, 8'h03);
        wr(8'hF1, 8'h01);
        // Clear with the enable, since the loop left a count far above the new period.
        wr(8'hEF, 8'hD8);
        repeat (10) @(posedge ref_clk);
        #1;
        check("irq", {7'h00, irq}, 8'h00);
        rd(8'hEF, 8'hC9);
        highs(8'h02);
        wr(8'hEF, 8'hE8);
        highs(8'h06);
        @(posedge ref_clk);
        // Driving the comparator input directly stands for a linkage already enabled.
        comparator_zero <= 1'b1;
        wr(8'hEF, 8'hEC);
        highs(8'h08);
        wr(8'hEF, 8'hCC);
        highs(8'h00);
        @(posedge ref_clk);
        comparator_zero <= 1'b0;
        wr(8'hEF, 8'hC1);
        rd(8'hEF, 8'hC1);
        wr(8'hEF, 8'hC3);
        repeat (2) @(posedge ref_clk);
        #1;
        check("irq", {7'h00, irq}, 8'h01);
        wr(8'hEF, 8'hC2);
        repeat (2) @(posedge ref_clk);
        #1;
        check("irq", {7'h00, irq}, 8'h00);
        rd(8'hEF, 8'hC2);
        results();
    end
endmodule
